// File: dtp_defs.vh
// Constants for the dual touch probe position latch.
// Assumes inclusion by bare name from design files of the latch.
`ifndef DTP_DEFS_VH
`define DTP_DEFS_VH

// Object indices of the register map
`define DTP_IDX_CONTROL      16'h60B8
`define DTP_IDX_STATUS       16'h60B9
`define DTP_IDX_POS_ONE      16'h60BA
`define DTP_IDX_POS_TWO      16'h60BC

// Reset values
`define DTP_CONTROL_RESET    16'h0000
`define DTP_POS_RESET        32'h0000_0000

// Control field positions within one probe's byte
`define DTP_CB_ENABLE        0
`define DTP_CB_CONT          1
`define DTP_CB_SOURCE        2
`define DTP_CB_SAMPLE        4

// Status field positions within one probe's byte
`define DTP_SB_ENABLED       0
`define DTP_SB_HELD          1
`define DTP_SB_TOGGLE        7

// Byte offsets of the two probes inside control and status words
`define DTP_PROBE_ONE_LSB    0
`define DTP_PROBE_TWO_LSB    8

`endif

// File: dtp_channel.v
// One touch probe channel: arming, trigger selection, capture and status.
// Assumes trigger inputs are synchronous to core_clk and position is valid each cycle.
`include "dtp_defs.vh"

module dtp_channel (
    // Clock and reset
    input  wire        core_clk,
    input  wire        resetn,
    // Control byte for this probe
    input  wire [7:0]  ctrl_byte,
    input  wire        force_off,
    // Trigger candidates and position
    input  wire        trig_ext,
    input  wire        trig_index,
    input  wire [31:0] position,
    // Results
    output wire [7:0]  stat_byte,
    output reg  [31:0] latched_q
);

    // Control field decode
    wire enable  = ctrl_byte[`DTP_CB_ENABLE] & ~force_off;
    wire cont    = ctrl_byte[`DTP_CB_CONT];
    wire sample  = ctrl_byte[`DTP_CB_SAMPLE] & enable;

    reg        sample_q;
    reg        armed_q;
    reg        held_q;
    reg        toggle_q;
    reg        src_q;
    reg        ext_q;
    reg        idx_q;

    // Trigger source taken at each latch start; reread after each capture in continuous mode
    wire src_now  = ctrl_byte[`DTP_CB_SOURCE];
    wire sel_in   = src_q ? trig_index : trig_ext;
    wire sel_prev = src_q ? idx_q : ext_q;
    wire trig_evt = sel_in & ~sel_prev;
    wire start    = sample & ~sample_q;
    wire capture  = sample & ~start & trig_evt & (cont | armed_q);

    // Arming, capture and status state
    always @(posedge core_clk) begin
        if (!resetn) begin
            sample_q  <= 1'b0;
            armed_q   <= 1'b0;
            held_q    <= 1'b0;
            toggle_q  <= 1'b0;
            src_q     <= 1'b0;
            ext_q     <= 1'b0;
            idx_q     <= 1'b0;
            latched_q <= `DTP_POS_RESET;
        end else begin
            sample_q <= sample;
            ext_q    <= trig_ext;
            idx_q    <= trig_index;
            if (start || (cont && capture))
                src_q <= src_now;
            if (!enable || start) begin
                held_q  <= 1'b0;
                armed_q <= start;
            end else if (capture) begin
                latched_q <= position;
                held_q    <= 1'b1;
                armed_q   <= 1'b0;
                if (cont)
                    toggle_q <= ~toggle_q;
            end
        end
    end

    // Status byte for this probe
    assign stat_byte = {toggle_q, 5'b0_0000, held_q, enable};

endmodule

// File: dtp_latch.v
// Top of the dual touch probe position latch with its object register port.
// Assumes host accesses arrive synchronous to core_clk as index, write strobe and data.
// Assumes the host reads an object by holding its index for one clock.
// Assumes trigger inputs and position need no filtering and are valid every cycle.
`include "dtp_defs.vh"

module dtp_latch (
    // Clock and reset
    input  wire        core_clk,
    input  wire        resetn,
    // Object access port
    input  wire [15:0] obj_index,
    input  wire        obj_write,
    input  wire [31:0] obj_wdata,
    output reg  [31:0] obj_rdata,
    output reg         obj_valid,
    // Drive context
    input  wire        homing_active,
    input  wire [31:0] actual_position,
    // Trigger inputs
    input  wire        first_probe_input,
    input  wire        second_probe_input,
    input  wire        encoder_index
);

    // The block keeps one control word; status and positions are
    // assembled from the two channels and read back through one mux.

    // Stored control word and its next value
    reg  [15:0] control_q;
    reg  [15:0] control_d;
    wire [15:0] ctrl_wdata;

    // Previous homing level and the start-of-homing pulse
    reg         homing_q;
    wire        homing_start;

    // Index decode results, one object at a time
    reg         sel_control;
    reg         sel_status;
    reg         sel_pos_one;
    reg         sel_pos_two;
    wire        sel_mapped;
    wire        ctrl_wr;

    // Control bytes handed to the two channels
    wire [7:0]  ctrl_one;
    wire [7:0]  ctrl_two;

    // Trigger and position routing into the channels
    wire        trig_one_ext;
    wire        trig_one_index;
    wire        trig_two_ext;
    wire        trig_two_alt;
    wire [31:0] position_now;

    // Channel results
    wire [7:0]  stat_one;
    wire [7:0]  stat_two;
    wire [15:0] status_word;
    wire [31:0] pos_one;
    wire [31:0] pos_two;

    // Read path next values
    reg  [31:0] rdata_d;
    reg         valid_d;

    // Index decode as a priority chain; each object answers only at
    // its exact index, so neighbouring indices never alias onto it
    always @* begin
        sel_control = 1'b0;
        sel_status  = 1'b0;
        sel_pos_one = 1'b0;
        sel_pos_two = 1'b0;
        if (obj_index == `DTP_IDX_CONTROL) begin
            sel_control = 1'b1;
        end else if (obj_index == `DTP_IDX_STATUS) begin
            sel_status = 1'b1;
        end else if (obj_index == `DTP_IDX_POS_ONE) begin
            sel_pos_one = 1'b1;
        end else if (obj_index == `DTP_IDX_POS_TWO) begin
            sel_pos_two = 1'b1;
        end
    end

    // Any decoded object makes the read valid
    assign sel_mapped = sel_control | sel_status | sel_pos_one | sel_pos_two;

    // Write decode; status and both positions are read-only, so a write
    // aimed at them falls through here and leaves every register untouched
    assign ctrl_wr = obj_write & sel_control;

    // Only the low half of the write data is a control word;
    // the upper half is left unread
    assign ctrl_wdata = obj_wdata[15:0];

    // Previous homing level, kept to find the first cycle of a run
    always @(posedge core_clk) begin
        if (!resetn) begin
            homing_q <= 1'b0;
        end else begin
            homing_q <= homing_active;
        end
    end

    // One-cycle pulse in the first cycle of a homing run
    assign homing_start = homing_active & ~homing_q;

    // Control next value. A host write in the cycle that homing starts
    // wins; probe one is still held off by the homing level itself, so
    // a written enable only takes effect once homing has ended
    always @* begin
        control_d = control_q;
        if (ctrl_wr) begin
            control_d = ctrl_wdata;
        end else if (homing_start) begin
            control_d[`DTP_PROBE_ONE_LSB + `DTP_CB_ENABLE] = 1'b0;
        end
    end

    // Control register; reserved bits are kept and read back as written
    always @(posedge core_clk) begin
        if (!resetn) begin
            control_q <= `DTP_CONTROL_RESET;
        end else begin
            control_q <= control_d;
        end
    end

    // Low byte configures probe one, high byte probe two
    assign ctrl_one = control_q[`DTP_PROBE_ONE_LSB +: 8];
    assign ctrl_two = control_q[`DTP_PROBE_TWO_LSB +: 8];

    // Probe one chooses between its own input and the encoder index;
    // the source bit picks between them inside the channel
    assign trig_one_ext   = first_probe_input;
    assign trig_one_index = encoder_index;

    // Probe two has one trigger line: bit 10 at one is reserved, so both
    // candidates are the second probe input and the source bit cannot
    // steer probe two anywhere else
    assign trig_two_ext = second_probe_input;
    assign trig_two_alt = second_probe_input;

    // Both channels latch the same live position
    assign position_now = actual_position;

    // A trigger edge is latched at the clock that sees it; the host can
    // read the new position and status one clock later at the earliest.
    // Probe one channel; homing holds it off for as long as it runs
    dtp_channel u_probe_one (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .ctrl_byte  (ctrl_one),
        .force_off  (homing_active),
        .trig_ext   (trig_one_ext),
        .trig_index (trig_one_index),
        .position   (position_now),
        .stat_byte  (stat_one),
        .latched_q  (pos_one)
    );

    // Probe two channel; nothing outside forces it off
    dtp_channel u_probe_two (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .ctrl_byte  (ctrl_two),
        .force_off  (1'b0),
        .trig_ext   (trig_two_ext),
        .trig_index (trig_two_alt),
        .position   (position_now),
        .stat_byte  (stat_two),
        .latched_q  (pos_two)
    );

    // Status word: probe two in the high byte, probe one in the low byte;
    // reserved status bits come out zero from the channels
    assign status_word = {stat_two, stat_one};

    // Read mux; 16-bit objects sit in the low half with the upper half
    // zero, and an unknown index answers zero with valid low
    always @* begin
        rdata_d = 32'h0000_0000;
        valid_d = sel_mapped;
        if (sel_control) begin
            rdata_d = {16'h0000, control_q};
        end else if (sel_status) begin
            rdata_d = {16'h0000, status_word};
        end else if (sel_pos_one) begin
            rdata_d = pos_one;
        end else if (sel_pos_two) begin
            rdata_d = pos_two;
        end
    end

    // Registered read-back, one cycle after the index is presented; the
    // register keeps the host's sample point clear of the mux ripple
    always @(posedge core_clk) begin
        if (!resetn) begin
            obj_rdata <= 32'h0000_0000;
            obj_valid <= 1'b0;
        end else begin
            obj_rdata <= rdata_d;
            obj_valid <= valid_d;
        end
    end

endmodule

// File: dtp_latch_properties.sv
// Checker for the probe latch object port.
// Bound to dtp_latch; sees its ports only.
module dtp_latch_properties (
    input logic        core_clk,
    input logic        resetn,
    input logic [15:0] obj_index,
    input logic        obj_write,
    input logic [31:0] obj_wdata,
    input logic [31:0] obj_rdata,
    input logic        obj_valid,
    input logic        homing_active,
    input logic        first_probe_input,
    input logic        second_probe_input,
    input logic        encoder_index
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Index decodes used by several checks
    wire ix_b8 = obj_index == 16'h60B8;
    wire mapped = obj_index inside {16'h60B8, 16'h60B9, 16'h60BA, 16'h60BC};
    unmapped_quiet_a: assert property (!mapped |=> !obj_valid && obj_rdata == 32'h0000_0000)
        else $error("unmapped read answered");
    mapped_valid_a: assert property (mapped |=> obj_valid) else $error("mapped read not valid");
    reset_quiet_a: assert property ($rose(resetn) |-> !obj_valid && obj_rdata == 32'h0000_0000)
        else $error("read data not clear after reset");
    ctrl_readback_a: assert property (
        (obj_write && ix_b8 && !homing_active) ##1 (ix_b8 && !obj_write && !homing_active)
        |=> obj_rdata == {16'h0000, $past(obj_wdata[15:0], 2)}) else $error("control readback");
    status_reserved_a: assert property (obj_index == 16'h60B9 |=> obj_rdata[31:16] == 16'h0000
        && obj_rdata[6:2] == 5'h00 && obj_rdata[14:10] == 5'h00) else $error("status spare bits");
    homing_off_a: assert property (
        homing_active && $past(homing_active) && obj_index == 16'h60B9 |=> !obj_rdata[0])
        else $error("probe one on while homing");
    pos_one_hold_a: assert property (
        (obj_index == 16'h60BA && !$rose(first_probe_input) && !$rose(encoder_index))
        ##1 obj_index == 16'h60BA |=> $stable(obj_rdata)) else $error("probe one position moved");
    pos_two_hold_a: assert property (
        (obj_index == 16'h60BC && !$rose(second_probe_input)) ##1 obj_index == 16'h60BC
        |=> $stable(obj_rdata)) else $error("probe two position moved");
endmodule

bind dtp_latch dtp_latch_properties i_props (.*);

// File: dtp_probe_model.sv
// Model of the three trigger lines feeding the latch.
// Assumes requests come one edge ahead on core_clk.
module dtp_probe_model (
    input  logic       core_clk,
    input  logic [2:0] fire,
    output logic [2:0] trig
);
    timeunit 1ns;
    timeprecision 1ns;
    initial trig = 3'h0;
    // Each request becomes one high cycle, idle low
    always @(posedge core_clk) trig <= fire;
endmodule

// File: dtp_latch_bench.sv
// Self-checking bench for the probe latch.
// Assumes the trigger model drives the probe and index lines.
module dtp_latch_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, resetn = 0, obj_write = 0, homing_active = 0, rd = 0, p1 = 0;
    logic [15:0] obj_index = 16'h0000;
    logic [31:0] obj_wdata = 32'h0000_0000, actual_position = 32'h0000_0000, pa, pe, pf;
    logic [2:0]  fv = 3'h0;
    wire  [2:0]  trig;
    wire  [31:0] obj_rdata;
    wire         obj_valid;
    integer      seed = 32'h599b_ff23, err_count = 0, n_checks = 0, cyc = 0;
    logic [32:0] q[$];
    always #20 core_clk = ~core_clk;
    dtp_probe_model i_model (.core_clk(core_clk), .fire(fv), .trig(trig));
    dtp_latch i_dut (.core_clk(core_clk), .resetn(resetn), .obj_index(obj_index),
        .obj_write(obj_write), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
        .obj_valid(obj_valid), .homing_active(homing_active), .actual_position(actual_position),
        .first_probe_input(trig[0]), .second_probe_input(trig[1]), .encoder_index(trig[2]));
    task stop_test;
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input [32:0] s, input [32:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("Error obj_rdata expected %h seen %h", e, s);
        end
    endtask
    task wr(input [15:0] i, input [31:0] d);
        @(posedge core_clk);
        obj_write <= 1'b1;
        obj_index <= i;
        obj_wdata <= d;
        @(posedge core_clk);
        obj_write <= 1'b0;
    endtask
    // Read request; the answer is noted for the watcher
    task rc(input [15:0] i, input [32:0] e);
        @(posedge core_clk);
        obj_index <= i;
        rd <= 1'b1;
        q.push_back(e);
        @(posedge core_clk);
        rd <= 1'b0;
    endtask
    // New random position, then one trigger pulse
    task fire(input [2:0] f, output [31:0] p);
        @(posedge core_clk);
        p = $random(seed);
        actual_position <= p;
        fv <= f;
        @(posedge core_clk);
        fv <= 3'h0;
        repeat (2) @(posedge core_clk);
    endtask
    // Watcher compares each answer with the oldest note, and bounds the run
    always @(posedge core_clk) begin
        if (p1)
            chk({obj_valid, obj_rdata}, q.pop_front());
        p1 <= rd;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            stop_test;
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        rc(16'h60B8, 33'h1_0000_0000);
        rc(16'h60BB, 33'h0_0000_0000);
        wr(16'h60B8, 32'h0000_0011);
        rc(16'h60B9, 33'h1_0000_0001);
        fire(3'h1, pa);
        fire(3'h1, pe);
        wr(16'h60BA, ~pa);
        rc(16'h60BA, {1'b1, pa});
        rc(16'h60B9, 33'h1_0000_0003);
        wr(16'h60B8, 32'h0000_0001);
        wr(16'h60B8, 32'h0000_0013);
        rc(16'h60B9, 33'h1_0000_0001);
        fire(3'h1, pa);
        rc(16'h60BA, {1'b1, pa});
        rc(16'h60B9, 33'h1_0000_0083);
        wr(16'h60B8, 32'h0000_0017);
        fire(3'h1, pa);
        fire(3'h4, pe);
        rc(16'h60BA, {1'b1, pe});
        rc(16'h60B9, 33'h1_0000_0083);
        wr(16'h60B8, 32'h0000_1100);
        fire(3'h2, pf);
        fire(3'h1, pa);
        rc(16'h60BC, {1'b1, pf});
        rc(16'h60B9, 33'h1_0000_0380);
        wr(16'h60B8, 32'h0000_1300);
        fire(3'h2, pf);
        rc(16'h60BC, {1'b1, pf});
        rc(16'h60B9, 33'h1_0000_8380);
        wr(16'h60B8, 32'h0000_0011);
        @(posedge core_clk);
        homing_active <= 1'b1;
        @(posedge core_clk);
        rc(16'h60B9, 33'h1_0000_8080);
        rc(16'h60B8, 33'h1_0000_0010);
        repeat (3) @(posedge core_clk);
        stop_test;
    end
endmodule
